// ### rtl/lfrc_top.sv
// receiver control page: wishbone registers and the decoder logic they steer
// How it works
// - error-behaviour bit 0: any decode error ends the ON window
// - error-behaviour bit 1 with ON time left: error returns receiver to sniff
// - error-behaviour bit resets to 0 and is software read/write
// - check codes 00/11 use 2x32 us packets, 01/10 use 8x8 us packets
// - paged registers are reachable only while page-select bit is 1; otherwise they read zero and ignore writes
// - data auto-zero enable bit 3 allows auto-zero in data frames
// - damping enable bit 0 turns input damping on or off
// - polarity 0: mid-bit fall is zero, rise is one; 1 inverts
// - polarity ignored in carrier mode and cleared by reset
// - 3-bit edge count sets least data edges between auto-zero requests outside jitter mode, which draws count-1, count or count+1
// - filter codes 00/01 low-pass, 10 bi-phase low, 11 bi-phase high offset
// - trigger mode: after count, count with jitter, or count plus data level
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
module lfrc_top
    import lfrc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [7:0] dat_i,
    input wire logic sel_i,
    output logic [7:0] dat_o,
    output logic ack_o,
    input wire logic [3:0] carrier_detect_time_setting_i,
    input wire logic carrier_i,
    input wire logic carrier_mode_i,
    input wire logic mid_edge_i,
    input wire logic data_level_i,
    input wire logic data_edge_i,
    input wire logic decode_error_i,
    input wire logic on_time_left_i,
    output logic end_on_window_o,
    output logic go_sniff_o,
    output logic carrier_valid_o,
    output logic data_bit_o,
    output logic data_bit_valid_o,
    output logic auto_zero_req_o,
    output logic q_damping_on_o,
    output logic biphase_on_o,
    output logic high_offset_o
);
    logic [7:0] ctrl_d_ff;
    logic [7:0] ctrl_c_ff;
    logic [7:0] ctrl_b_ff;
    logic page_ff;
    logic [7:0] dat_ff;
    logic ack_ff;
    logic [7:0] nxt_dat;

    // bus decode; paged registers hidden while the page bit is clear
    wire req = cyc_i && stb_i && !ack_ff;
    wire wr = req && we_i && sel_i;
    wire hit_d = page_ff && adr_i == LFRC_OFS_D;
    wire hit_c = page_ff && adr_i == LFRC_OFS_C;
    wire hit_b = page_ff && adr_i == LFRC_OFS_B;
    wire hit_p = adr_i == LFRC_OFS_PAGE;
    wire hit_s = adr_i == LFRC_OFS_STAT;

    // decoded fields
    wire error_behaviour_select = ctrl_d_ff[LFRC_D_ERROR_BEHAVIOUR_SELECT];
    wire [1:0] chk = ctrl_d_ff[1:0];
    wire [1:0] trig = ctrl_d_ff[LFRC_D_TRIG_LO +: 2];
    wire az_en = ctrl_c_ff[LFRC_C_DATA_AUTOZERO_ENABLE];
    wire q_en = ctrl_c_ff[LFRC_C_QEN];
    wire pol = ctrl_b_ff[LFRC_B_POL];
    wire [1:0] filt = ctrl_b_ff[LFRC_B_FILT_LO +: 2];
    wire [2:0] az_cnt = ctrl_b_ff[LFRC_B_CNT_LO +: 3];

    // read mux; unmapped or hidden addresses read zero
    always_comb begin
        nxt_dat = 8'h00;
        if (hit_d) begin
            nxt_dat = {ctrl_d_ff[7:6], q_damping_on_o, ctrl_d_ff[4:0]};
        end else if (hit_c) begin
            nxt_dat = ctrl_c_ff;
        end else if (hit_b) begin
            nxt_dat = ctrl_b_ff;
        end else if (hit_p) begin
            nxt_dat = {7'h00, page_ff};
        end else if (hit_s) begin
            nxt_dat = {5'h00, auto_zero_req_o, carrier_valid_o, data_bit_o};
        end
    end

    // single-wait answer: ack one cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 8'h00;
        end else begin
            ack_ff <= req;
            dat_ff <= req ? nxt_dat : 8'h00;
        end
    end
    assign ack_o = ack_ff;
    assign dat_o = dat_ff;

    // register writes; a write with page clear reaches only the page register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_d_ff <= LFRC_RST_D;
            ctrl_c_ff <= LFRC_RST_C;
            ctrl_b_ff <= LFRC_RST_B;
            page_ff <= 1'b0;
        end else begin
            if (wr && hit_d) begin
                ctrl_d_ff <= dat_i & LFRC_D_WMASK;
            end
            if (wr && hit_c) begin
                ctrl_c_ff <= dat_i;
            end
            if (wr && hit_b) begin
                ctrl_b_ff <= dat_i;
            end
            if (wr && hit_p) begin
                page_ff <= dat_i[0];
            end
        end
    end

    // error handling of the ON window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            end_on_window_o <= 1'b0;
            go_sniff_o <= 1'b0;
        end else begin
            go_sniff_o <= decode_error_i && error_behaviour_select && on_time_left_i;
            end_on_window_o <= decode_error_i &&
                !(error_behaviour_select && on_time_left_i);
        end
    end

    // carrier validator: n+1 packets of 2x32 us or 8x8 us
    localparam int SUBW = 9;
    logic [SUBW-1:0] sub_ff;
    logic [3:0] subs_ff;
    logic [4:0] pkts_ff;
    wire short_pkt = chk[0] ^ chk[1];
    wire [SUBW-1:0] sub_max = short_pkt ?
        SUBW'(LFRC_SUB_SHORT_CYC - 1) : SUBW'(LFRC_SUB_LONG_CYC - 1);
    wire [3:0] subs_max = short_pkt ? 4'h7 : 4'h1;
    wire sub_end = sub_ff == sub_max;
    wire pkt_end = sub_end && subs_ff == subs_max;
    wire [4:0] n_pkts = {1'b0, carrier_detect_time_setting_i} + 5'h01;
    always_ff @(posedge clk_i) begin
        if (rst_i || !carrier_i) begin
            sub_ff <= '0;
            subs_ff <= 4'h0;
            pkts_ff <= 5'h00;
            carrier_valid_o <= 1'b0;
        end else begin
            sub_ff <= sub_end ? '0 : sub_ff + 1'b1;
            if (sub_end) begin
                subs_ff <= pkt_end ? 4'h0 : subs_ff + 4'h1;
            end
            if (pkt_end && pkts_ff != n_pkts) begin
                pkts_ff <= pkts_ff + 5'h01;
            end
            carrier_valid_o <= pkts_ff == n_pkts;
        end
    end

    // manchester decode; no bit decoded in carrier mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_bit_o <= 1'b0;
            data_bit_valid_o <= 1'b0;
        end else begin
            data_bit_valid_o <= mid_edge_i && !carrier_mode_i;
            if (mid_edge_i && !carrier_mode_i) begin
                data_bit_o <= data_level_i ^ pol;
            end
        end
    end

    // auto-zero trigger: edge count with mode and enable
    logic [3:0] edges_ff;
    logic [3:0] target_ff;
    logic [7:0] lfsr_ff;
    wire [3:0] base = {1'b0, az_cnt};
    wire [3:0] jit_t = lfsr_ff[1:0] == 2'h0 ? base - 4'h1 :
        lfsr_ff[1:0] == 2'h1 ? base + 4'h1 : base;
    // plain modes follow the field at once; only jitter mode uses the latch
    wire [3:0] goal = trig == LFRC_TRIG_RAND ? target_ff : base;
    wire count_met = edges_ff >= goal;
    wire level_ok = trig == LFRC_TRIG_LOW ? !data_level_i :
        trig == LFRC_TRIG_HIGH ? data_level_i : 1'b1;
    wire fire = az_en && !carrier_mode_i && count_met && level_ok;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edges_ff <= 4'h0;
            target_ff <= 4'h4;
            lfsr_ff <= 8'h01;
            auto_zero_req_o <= 1'b0;
        end else begin
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5]};
            auto_zero_req_o <= fire;
            if (fire) begin
                edges_ff <= 4'h0;
                target_ff <= trig == LFRC_TRIG_RAND ? jit_t : base;
            end else if (data_edge_i && edges_ff != 4'hF) begin
                edges_ff <= edges_ff + 4'h1;
            end
        end
    end

    // analog-facing controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_damping_on_o <= 1'b0;
            biphase_on_o <= 1'b0;
            high_offset_o <= 1'b0;
        end else begin
            q_damping_on_o <= q_en;
            biphase_on_o <= filt[1];
            high_offset_o <= filt == 2'h3;
        end
    end

    // register bits steer outputs one cycle after the write lands

    // bus steps: a request is answered next cycle, and only for one cycle
    sequence s_bus_req;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence s_bus_ack;
        ack_o ##1 !ack_o;
    endsequence

    // reset state of the paged bits that software relies on
    a_error_behaviour_select_reset: assert property (@(posedge clk_i)
        rst_i |=> ctrl_d_ff == LFRC_RST_D)
        else $error("error mode not cleared");

    a_pol_reset: assert property (@(posedge clk_i)
        rst_i |=> !ctrl_b_ff[LFRC_B_POL])
        else $error("polarity not cleared");

    // error handling of the ON window
    a_err_end: assert property (@(posedge clk_i) disable iff (rst_i)
        decode_error_i && !error_behaviour_select |=> end_on_window_o && !go_sniff_o)
        else $error("error did not end window");

    a_err_notime: assert property (@(posedge clk_i) disable iff (rst_i)
        decode_error_i && !on_time_left_i |=>
        end_on_window_o && !go_sniff_o)
        else $error("error without time left kept window");

    a_err_sniff: assert property (@(posedge clk_i) disable iff (rst_i)
        decode_error_i && error_behaviour_select && on_time_left_i |=>
        go_sniff_o && !end_on_window_o)
        else $error("error did not go to sniff");

    // bus answer and page gating
    a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        s_bus_req |=> s_bus_ack)
        else $error("bus request not answered once");

    a_page_block: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && !page_ff |=> $stable(ctrl_b_ff) && $stable(ctrl_c_ff) &&
        $stable(ctrl_d_ff))
        else $error("hidden write changed register");

    a_page_read: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !page_ff && adr_i == LFRC_OFS_C |=> ack_o && dat_o == 8'h00)
        else $error("hidden read not zero");

    a_d_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && hit_d |=>
        dat_o[LFRC_D_ERROR_BEHAVIOUR_SELECT] == $past(error_behaviour_select))
        else $error("error mode bit not readable");

    // analog-facing controls follow their bits
    a_qdamp_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && hit_c |=> ##1 q_damping_on_o == $past(dat_i[0], 2))
        else $error("damping does not follow bit");

    a_filter_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        !filt[1] |=> !biphase_on_o && !high_offset_o)
        else $error("bi-phase on for low-pass code");

    a_filter_high: assert property (@(posedge clk_i) disable iff (rst_i)
        filt == 2'h3 |=> biphase_on_o && high_offset_o)
        else $error("high offset code not applied");

    // manchester decode
    a_pol_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        mid_edge_i && !carrier_mode_i |=>
        data_bit_o == ($past(data_level_i) ^ $past(pol)))
        else $error("manchester polarity wrong");

    a_carrier_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
        carrier_mode_i |=> !data_bit_valid_o && !auto_zero_req_o)
        else $error("decode active in carrier mode");

    // auto-zero requests
    a_az_disable: assert property (@(posedge clk_i) disable iff (rst_i)
        !az_en |=> !auto_zero_req_o)
        else $error("auto-zero while disabled");

    a_az_level: assert property (@(posedge clk_i) disable iff (rst_i)
        trig == LFRC_TRIG_HIGH && !data_level_i |=> !auto_zero_req_o)
        else $error("auto-zero ignored data level");

    a_az_low: assert property (@(posedge clk_i) disable iff (rst_i)
        trig == LFRC_TRIG_LOW && data_level_i |=> !auto_zero_req_o)
        else $error("auto-zero ignored low level");

    a_edge_min: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_zero_req_o |-> $past(edges_ff) >= $past(goal))
        else $error("auto-zero before edge count");

    // carrier validator
    a_valid_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        !carrier_i |=> !carrier_valid_o)
        else $error("carrier valid without carrier");

    a_valid_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        carrier_valid_o && carrier_i |=> carrier_valid_o)
        else $error("carrier valid dropped under carrier");

endmodule : lfrc_top

// ### pkg/lfrc_pkg.sv
// register map, field positions and reset values of the receiver page
package lfrc_pkg;
    localparam logic [7:0] LFRC_OFS_D = 8'h22;
    localparam logic [7:0] LFRC_OFS_C = 8'h23;
    localparam logic [7:0] LFRC_OFS_B = 8'h24;
    localparam logic [7:0] LFRC_OFS_PAGE = 8'h30;
    localparam logic [7:0] LFRC_OFS_STAT = 8'h31;
    localparam logic [7:0] LFRC_RST_D = 8'h00;
    localparam logic [7:0] LFRC_RST_C = 8'hC8;
    localparam logic [7:0] LFRC_RST_B = 8'hC4;
    localparam logic [7:0] LFRC_D_WMASK = 8'hDF;
    localparam int LFRC_D_ERROR_BEHAVIOUR_SELECT = 2;
    localparam int LFRC_D_QSTAT = 5;
    localparam int LFRC_D_TRIG_LO = 3;
    localparam int LFRC_C_DATA_AUTOZERO_ENABLE = 3;
    localparam int LFRC_C_QEN = 0;
    localparam int LFRC_B_POL = 3;
    localparam int LFRC_B_FILT_LO = 4;
    localparam int LFRC_B_CNT_LO = 0;
    localparam logic [1:0] LFRC_TRIG_PLAIN = 2'h0;
    localparam logic [1:0] LFRC_TRIG_RAND = 2'h1;
    localparam logic [1:0] LFRC_TRIG_LOW = 2'h2;
    localparam logic [1:0] LFRC_TRIG_HIGH = 2'h3;
    // carrier packets: 2 x 32 us or 8 x 8 us, 10 MHz clock
    localparam int LFRC_CLK_KHZ = 10000;
    localparam int LFRC_PKT_LONG_US = 64;
    localparam int LFRC_PKT_SHORT_US = 64;
    localparam int LFRC_SUB_LONG_US = 32;
    localparam int LFRC_SUB_SHORT_US = 8;
    localparam int LFRC_SUB_LONG_CYC = LFRC_SUB_LONG_US * LFRC_CLK_KHZ / 1000;
    localparam int LFRC_SUB_SHORT_CYC =
        LFRC_SUB_SHORT_US * LFRC_CLK_KHZ / 1000;
endpackage : lfrc_pkg

// ### tb/lfrc_antenna.sv
// far-side model of the low-frequency antenna signal seen by the receiver
`timescale 1ns/1ps
module lfrc_antenna (
    input wire logic clk_i,
    output logic carrier_o,
    output logic mid_edge_o,
    output logic data_level_o,
    output logic data_edge_o
);
    // quiet antenna: no carrier, no edges
    initial begin
        carrier_o = 1'b0;
        mid_edge_o = 1'b0;
        data_level_o = 1'b0;
        data_edge_o = 1'b0;
    end

    // carrier burst is a plain level, held until switched off
    task automatic carrier(input logic on);
        carrier_o <= on;
        @(posedge clk_i);
    endtask : carrier

    // spaced edges; the level toggles so each edge is a real one
    task automatic edges(input int n);
        repeat (n) begin
            data_level_o <= ~data_level_o;
            data_edge_o <= 1'b1;
            @(posedge clk_i);
            data_edge_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask : edges

    // mid-bit transition ending at the given level
    task automatic mid(input logic lvl);
        data_level_o <= lvl;
        mid_edge_o <= 1'b1;
        @(posedge clk_i);
        mid_edge_o <= 1'b0;
    endtask : mid
endmodule : lfrc_antenna

// ### tb/tb_top.sv
// register and decoder tests of the receiver control page
`timescale 1ns/1ps
module tb_top;
    import lfrc_pkg::*;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, sel_i, cmode, err, tleft;
    logic [7:0] adr_i, dat_i, dat_o, q;
    logic ack_o, car, mid, lvl, edg, endw, sniff, cval, dbit, dval;
    logic azr, qd, bph, hof;
    logic [3:0] cdt;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    logic s;

    lfrc_antenna ant (.clk_i(clk_i), .carrier_o(car), .mid_edge_o(mid),
        .data_level_o(lvl), .data_edge_o(edg));
    lfrc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
        .dat_o(dat_o), .ack_o(ack_o), .carrier_detect_time_setting_i(cdt),
        .carrier_i(car), .carrier_mode_i(cmode), .mid_edge_i(mid),
        .data_level_i(lvl), .data_edge_i(edg), .decode_error_i(err),
        .on_time_left_i(tleft), .end_on_window_o(endw), .go_sniff_o(sniff),
        .carrier_valid_o(cval), .data_bit_o(dbit), .data_bit_valid_o(dval),
        .auto_zero_req_o(azr), .q_damping_on_o(qd), .biphase_on_o(bph),
        .high_offset_o(hof));

    // 10 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic report_and_stop;
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // classic cycle; request held until ack is seen at an edge
    task automatic bus(input logic w, input logic [7:0] a, d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic rd(input logic [7:0] a, exp);
        bus(1'b0, a, 8'h00);
        check("read", q, exp);
    endtask : rd

    // sticky watch of the auto-zero request over n cycles
    task automatic az_watch(input int n);
        s = 1'b0;
        repeat (n) begin
            @(posedge clk_i);
            if (azr === 1'b1) s = 1'b1;
        end
    endtask : az_watch

    // hang guard, well above the longest expected run
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        {cyc_i, stb_i, we_i, cmode, err, tleft} = '0;
        {adr_i, dat_i} = '0;
        sel_i = 1'b1;
        cdt = 4'h1;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // page closed: paged registers read zero and ignore writes
        rd(LFRC_OFS_C, 8'h00);
        bus(1'b1, LFRC_OFS_C, 8'h01);
        bus(1'b1, LFRC_OFS_PAGE, 8'h01);
        rd(LFRC_OFS_C, 8'hC8);
        sel_i <= 1'b0;
        bus(1'b1, LFRC_OFS_C, 8'h01);
        sel_i <= 1'b1;
        rd(LFRC_OFS_C, 8'hC8);
        rd(LFRC_OFS_D, 8'h00);
        rd(LFRC_OFS_B, 8'hC4);
        rd(8'h40, 8'h00);
        bus(1'b1, LFRC_OFS_D, 8'hFF);
        rd(LFRC_OFS_D, 8'hDF);
        bus(1'b1, LFRC_OFS_C, 8'hC9);
        check("qdamp", qd, 8'h01);
        rd(LFRC_OFS_D, 8'hFF);
        bus(1'b1, LFRC_OFS_C, 8'hC8);
        check("qdamp", qd, 8'h00);
        // every filter code, ending on low-pass with edge count six
        for (int c = 3; c >= 0; c--) begin
            bus(1'b1, LFRC_OFS_B, 8'hC6 | 8'(c << 4));
            check("filter", {bph, hof}, 8'(c == 3 ? 3 : c == 2 ? 2 : 0));
        end
        // error handling: stop, sniff, and no time left
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, LFRC_OFS_D, i == 0 ? 8'h00 : 8'h04);
            err <= 1'b1;
            tleft <= (i != 2);
            @(posedge clk_i);
            err <= 1'b0;
            @(negedge clk_i);
            check("onwin", {endw, sniff}, i == 1 ? 8'h01 : 8'h02);
            @(posedge clk_i);
        end
        bus(1'b1, LFRC_OFS_D, 8'h00);
        // mid-bit polarity for both settings and both levels
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, LFRC_OFS_B, 8'hC6 | 8'(p << 3));
            for (int l = 0; l < 2; l++) begin
                ant.mid(l[0]);
                for (int k = 0; k < 8 && dval !== 1'b1; k++) @(posedge clk_i);
                check("bit", {dval, dbit}, {7'h01, l[0] ^ p[0]});
            end
        end
        bus(1'b1, LFRC_OFS_B, 8'hC6);
        // carrier mode: no bit decoded
        cmode <= 1'b1;
        ant.mid(1'b1);
        @(posedge clk_i);
        check("cmode", dval, 8'h00);
        cmode <= 1'b0;
        // auto-zero after exactly six data edges, then disabled
        fork ant.edges(5); az_watch(24); join
        check("az_early", s, 8'h00);
        fork ant.edges(1); az_watch(8); join
        check("az_due", s, 8'h01);
        // jitter mode: first target still six edges
        bus(1'b1, LFRC_OFS_D, 8'h08);
        fork ant.edges(4); az_watch(20); join
        check("az_rnd_early", s, 8'h00);
        fork ant.edges(3); az_watch(16); join
        check("az_rnd_due", s, 8'h01);
        bus(1'b1, LFRC_OFS_C, 8'hC0);
        fork ant.edges(7); az_watch(32); join
        check("az_off", s, 8'h00);
        // carrier needs n+1 = 2 packets of 64 us for check codes 00 to 10
        // last code runs with n = 0: a single packet suffices
        for (int c = 0; c < 4; c++) begin
            cdt <= (c == 3) ? 4'h0 : 4'h1;
            bus(1'b1, LFRC_OFS_D, 8'(c));
            ant.carrier(1'b1);
            repeat (c == 3 ? 560 : 1200) @(posedge clk_i);
            check("car_early", cval, 8'h00);
            repeat (200) @(posedge clk_i);
            check("car_valid", cval, 8'h01);
            ant.carrier(1'b0);
            repeat (4) @(posedge clk_i);
        end
        report_and_stop();
    end
endmodule : tb_top
